// file: hdl/link_host_control_regs.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
module link_host_control_regs
  import link_host_pkg::*;
#(
  parameter logic [31:0] identity_value = 32'h5eed_0c1a  // arbitrary value
) (
  input wire logic clk_i,                // 20 mhz host bus clock
  input wire logic rst_i,                // synchronous reset, high
  input wire logic ce_i,                 // clock enable, freezes state when low
  input wire logic soft_reset_i,         // soft reset pulse from the controller
  input wire logic eeprom_load_i,        // eeprom load strobe
  input wire logic eeprom_permit_i,      // permit value from eeprom
  input wire logic pw_fail_i,            // posted write failure pulse
  input wire pw_fail_type pw_fail_info_i, // requester and offset of failure
  input wire logic cyc_i,                // wishbone cycle
  input wire logic stb_i,                // wishbone strobe
  input wire logic we_i,                 // wishbone write enable
  input wire logic [7:0] adr_i,          // wishbone byte address
  input wire logic [3:0] sel_i,          // wishbone byte selects
  input wire logic [31:0] dat_i,         // wishbone write data
  output logic [31:0] dat_o,             // wishbone read data
  output logic ack_o,                    // wishbone acknowledge
  output host_ctl_type host_ctl_o,       // current control flags
  output logic irq_o                     // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // bus side
  logic ack_q;
  logic req;
  logic wr;
  logic [31:0] wmask;

  // decoded write strobes, each already qualified by the clock enable
  logic set_hit;
  logic clr_hit;
  logic stat_hit;
  logic mask_hit;
  logic soft_hit;
  logic load_hit;

  // control flags, one register per flag
  logic swap_q;
  logic swap_d;
  logic permit_q;
  logic permit_d;
  logic enhance_q;
  logic enhance_d;
  logic link_q;
  logic link_d;
  logic [31:0] ctl_view;

  // failure capture
  pw_fail_type fail_q;

  // interrupt status and mask
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_event;
  logic [1:0] irq_clear;

  // read path
  logic [31:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // expand the four byte selects into a bit mask for the write data
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{sel[i]}};
    end
    lane_mask = m;
  endfunction

  // true for a write request that lands on the given register offset
  function automatic logic write_to(
    input logic wr_en,
    input logic [7:0] adr,
    input logic [7:0] target
  );
    write_to = wr_en && (adr == target);
  endfunction

  // common next value of a set/clear flag; set and clear never meet in one
  // write because they sit on different addresses
  function automatic logic flag_next(
    input logic cur,
    input logic set_en,
    input logic set_bit,
    input logic clr_en,
    input logic clr_bit
  );
    logic nxt;
    nxt = cur;
    if (set_en && set_bit) begin
      nxt = 1'b1;
    end
    if (clr_en && clr_bit) begin
      nxt = 1'b0;
    end
    flag_next = nxt;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i && ce_i;
  assign wmask = dat_i & lane_mask(sel_i);

  assign set_hit = write_to(wr, adr_i, host_ctl_set_addr);
  assign clr_hit = write_to(wr, adr_i, host_ctl_clr_addr);
  assign stat_hit = write_to(wr, adr_i, irq_status_addr);
  assign mask_hit = write_to(wr, adr_i, irq_mask_addr);
  assign soft_hit = ce_i && soft_reset_i;
  assign load_hit = ce_i && eeprom_load_i;

  // one wait-free answer per request; ack drops the cycle after, which
  // also keeps a still-standing request from being taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req;
    end
  end

  // ack freezes with the clock enable, so a master simply waits longer
  // while the block is stalled
  assign ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // next values of the software-settable flags
  always_comb begin
    swap_d = flag_next(swap_q, set_hit, wmask[swap_bit],
                       clr_hit, wmask[swap_bit]);
    enhance_d = flag_next(enhance_q, set_hit, wmask[enhance_bit],
                          clr_hit, wmask[enhance_bit]);
    link_d = flag_next(link_q, set_hit, wmask[link_en_bit],
                       clr_hit, wmask[link_en_bit]);
  end

  // the permit flag has no set path: only the eeprom can raise it
  always_comb begin
    permit_d = permit_q;
    if (clr_hit && wmask[permit_bit]) begin
      permit_d = 1'b0;
    end
  end

  // swap control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swap_q <= 1'b0;
    end else if (soft_hit) begin
      swap_q <= 1'b0;
    end else if (ce_i) begin
      swap_q <= swap_d;
    end
  end

  // enhancement enable; software is trusted to raise it only while the
  // permit and link enable are both set, hardware does not police that
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enhance_q <= 1'b0;
    end else if (soft_hit) begin
      enhance_q <= 1'b0;
    end else if (ce_i) begin
      enhance_q <= enhance_d;
    end
  end

  // link enable: either reset drops it and cuts the link at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_q <= 1'b0;
    end else if (soft_hit) begin
      link_q <= 1'b0;
    end else if (ce_i) begin
      link_q <= link_d;
    end
  end

  // permit: an eeprom load wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      permit_q <= 1'b0;
    end else if (load_hit) begin
      permit_q <= eeprom_permit_i;
    end else if (ce_i) begin
      permit_q <= permit_d;
    end
  end

  // reserved and unimplemented bits have no storage and read as zero
  always_comb begin
    ctl_view = host_ctl_reset;
    ctl_view[swap_bit] = swap_q;
    ctl_view[permit_bit] = permit_q;
    ctl_view[enhance_bit] = enhance_q;
    ctl_view[link_en_bit] = link_q;
    ctl_view = ctl_view & host_ctl_clr_mask;
  end

  assign host_ctl_o.data_swap_inhibit = swap_q;
  assign host_ctl_o.enhancement_config_permit = permit_q;
  assign host_ctl_o.bus_enhancement_on = enhance_q;
  assign host_ctl_o.link_active_enable = link_q;

  ////////////////////////////////////////////////////////////////////////////
  // capture has no reset: it is undefined until the first failure, and
  // a later failure overwrites an earlier one that software has not read
  always_ff @(posedge clk_i) begin
    if (ce_i && pw_fail_i) begin
      fail_q.requester_node_number <= pw_fail_info_i.requester_node_number;
      fail_q.dest_offset_upper <= pw_fail_info_i.dest_offset_upper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events that raise a status bit
  always_comb begin
    irq_event = irq_reset;
    if (pw_fail_i) begin
      irq_event = irq_event | irq_pw_fail;
    end
    if (eeprom_load_i && !eeprom_permit_i) begin
      irq_event = irq_event | irq_permit_lost;
    end
  end

  // write-one-to-clear; the set side wins over a clear in one cycle
  always_comb begin
    irq_clear = irq_reset;
    if (stat_hit) begin
      irq_clear = wmask[1:0];
    end
  end

  always_comb begin
    irq_stat_d = (irq_stat_q & ~irq_clear) | irq_event;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= irq_reset;
    end else if (ce_i) begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= irq_reset;
    end else if (mask_hit) begin
      irq_mask_q <= wmask[1:0];
    end
  end

  // level output, high while any unmasked status bit stands
  assign irq_o = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // read data is decoded here and registered below, so it stands beside ack
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (adr_i)
      pw_fail_upper_addr: begin
        rdata_d = fail_q;
      end
      identity_addr: begin
        rdata_d = identity_value;
      end
      host_ctl_set_addr: begin
        rdata_d = ctl_view;
      end
      host_ctl_clr_addr: begin
        rdata_d = ctl_view;
      end
      irq_status_addr: begin
        rdata_d = {30'h0, irq_stat_q};
      end
      irq_mask_addr: begin
        rdata_d = {30'h0, irq_mask_q};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // unmapped offsets read zero; writes to the read-only offsets match no
  // write strobe above and are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (ce_i && req) begin
      dat_o <= rdata_d;
    end
  end

endmodule

// file: hdl/link_host_pkg.sv
// Functional notes
// - on a posted write failure the requester's bus and node number is caught in bits 31-16 of the upper capture register.
// - on the same failure the upper 16 bits of the destination offset are caught in bits 15-0 of that register.
// - the upper capture register at 3ch is read-only to software, updated only by hardware, undefined until a failure.
// - the identity register at 40h is read-only, returns a fixed constant, and writes have no effect.
// - one set of host-control flags is reached through a set address at 50h and a clear address at 54h, both reading the flags.
// - bit 31 and bits 29-24 are reserved, read as zero and ignore writes.
// - bit 30 is settable and clearable and steers byte swapping of outside physical and DMA data accesses.
// - bit 23 is loaded from the serial EEPROM and software can only clear it through the clear address.
// - link enable bit 17 is cleared by hardware or soft reset, and while zero the link is disconnected from the bus.
package link_host_pkg;

  localparam logic [7:0] pw_fail_upper_addr = 8'h3c;
  localparam logic [7:0] identity_addr = 8'h40;
  localparam logic [7:0] host_ctl_set_addr = 8'h50;
  localparam logic [7:0] host_ctl_clr_addr = 8'h54;
  localparam logic [7:0] irq_status_addr = 8'h58;
  localparam logic [7:0] irq_mask_addr = 8'h5c;

  localparam int swap_bit = 30;
  localparam int permit_bit = 23;
  localparam int enhance_bit = 22;
  localparam int link_en_bit = 17;

  // bits software may set, and bits software may clear
  localparam logic [31:0] host_ctl_set_mask = 32'h4042_0000;
  localparam logic [31:0] host_ctl_clr_mask = 32'h40c2_0000;
  localparam logic [31:0] host_ctl_reset = 32'h0000_0000;

  localparam logic [1:0] irq_pw_fail = 2'h1;
  localparam logic [1:0] irq_permit_lost = 2'h2;
  localparam logic [1:0] irq_reset = 2'h0;

  typedef struct packed {
    logic [15:0] requester_node_number;
    logic [15:0] dest_offset_upper;
  } pw_fail_type;

  typedef struct packed {
    logic data_swap_inhibit;
    logic enhancement_config_permit;
    logic bus_enhancement_on;
    logic link_active_enable;
  } host_ctl_type;

endpackage

// file: test/link_host_control_regs_props.sv
`timescale 1ns/1ns
module link_host_control_regs_props
  import link_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic soft_reset_i,
  input wire logic eeprom_load_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire host_ctl_type host_ctl_o
);
  logic take;
  logic wr;
  assign take = cyc_i && stb_i && ce_i && !ack_o;
  assign wr = take && we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack; take |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_one; ack_o && ce_i |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  // both control addresses share adr bits 7:3
  property p_rsvd;
    ack_o && $past(adr_i[7:3]) == 5'h0a |-> (dat_o & 32'hbf3d_ffff) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_flags;
    ack_o && !$past(we_i) && $past(adr_i[7:3]) == 5'h0a |->
      {dat_o[30], dat_o[23:22], dat_o[17]} == host_ctl_o;
  endproperty
  a_flags: assert property (p_flags) else $error("flag readback wrong");
  property p_set;
    wr && adr_i == 8'h50 && sel_i[3] && dat_i[30] && !soft_reset_i |=>
      host_ctl_o.data_swap_inhibit;
  endproperty
  a_set: assert property (p_set) else $error("swap not set");
  property p_nset;
    wr && adr_i == 8'h50 && !eeprom_load_i |=> !$rose(host_ctl_o.enhancement_config_permit);
  endproperty
  a_nset: assert property (p_nset) else $error("permit set by software");
  property p_clr;
    wr && adr_i == 8'h54 && sel_i[2] && dat_i[23] && !eeprom_load_i |=>
      !host_ctl_o.enhancement_config_permit;
  endproperty
  a_clr: assert property (p_clr) else $error("permit not cleared");
  property p_soft;
    soft_reset_i && ce_i |=> !host_ctl_o.link_active_enable && !host_ctl_o.data_swap_inhibit;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset ignored");
  property p_hold; !wr && !soft_reset_i && !eeprom_load_i |=> $stable(host_ctl_o); endproperty
  a_hold: assert property (p_hold) else $error("flags moved unprompted");
  c_set: cover property (wr && adr_i == 8'h50);
  c_clr: cover property (wr && adr_i == 8'h54);
  c_soft: cover property (soft_reset_i);
endmodule
bind link_host_control_regs link_host_control_regs_props props_u (.clk_i, .rst_i, .ce_i,
  .soft_reset_i, .eeprom_load_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .host_ctl_o);

// file: test/link_host_control_regs_tb.sv
`timescale 1ns/1ns
module link_host_control_regs_tb;
  import link_host_pkg::*;
  logic clk_i, rst_i, ce_i, soft_reset_i, eeprom_load_i, eeprom_permit_i, pw_fail_i;
  logic cyc_i, stb_i, we_i, ack_o, irq_o, r;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  pw_fail_type pw_fail_info_i;
  host_ctl_type host_ctl_o;
  int bad_count, checks;
  // identity value is arbitrary
  link_host_control_regs #(.identity_value(32'h1234_abcd)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .soft_reset_i(soft_reset_i),
    .eeprom_load_i(eeprom_load_i), .eeprom_permit_i(eeprom_permit_i),
    .pw_fail_i(pw_fail_i), .pw_fail_info_i(pw_fail_info_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .host_ctl_o(host_ctl_o), .irq_o(irq_o));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // waits on ack with a bound rather than assuming the one-cycle answer
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
    // ack is looked at mid-cycle where it is settled; the request is
    // released only after the rising edge that sees it high
    @(negedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (ack_o !== 1'b1) begin
      bad_count++;
      close_out;
    end
    rd = dat_o;
    @(posedge clk_i);
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ev(input logic [1:0] k);
    case (k)
      2'h0: soft_reset_i <= 1'b1;
      2'h1: eeprom_load_i <= 1'b1;
      default: pw_fail_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {soft_reset_i, eeprom_load_i, pw_fail_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
  initial begin
    {rst_i, ce_i, soft_reset_i, eeprom_load_i, eeprom_permit_i, pw_fail_i} = 6'h30;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = 47'h0;
    pw_fail_info_i = 32'hbeef_1234;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(8'h50, 32'h0);
    chk({28'h0, host_ctl_o}, 32'h0);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h1234_abcd);
    wb(1'b1, 8'h50, 32'h0082_0000);
    rdchk(8'h54, 32'h0002_0000);
    eeprom_permit_i <= 1'b1;
    ev(2'h1);
    rdchk(8'h50, 32'h0082_0000);
    wb(1'b1, 8'h50, 32'hffff_ffff, 4'h4);
    rdchk(8'h54, 32'h00c2_0000);
    wb(1'b1, 8'h50, 32'hffff_ffff);
    rdchk(8'h54, 32'h40c2_0000);
    chk({28'h0, host_ctl_o}, 32'hf);
    wb(1'b1, 8'h54, 32'h0080_0000);
    rdchk(8'h50, 32'h4042_0000);
    chk({28'h0, host_ctl_o}, 32'hb);
    ev(2'h0);
    rdchk(8'h50, 32'h0);
    chk({28'h0, host_ctl_o}, 32'h0);
    ev(2'h1);
    rdchk(8'h54, 32'h0080_0000);
    wb(1'b1, 8'h54, 32'hffff_ffff);
    rdchk(8'h54, 32'h0);
    ev(2'h2);
    wb(1'b1, 8'h3c, 32'h0);
    rdchk(8'h3c, 32'hbeef_1234);
    rdchk(8'h58, 32'h1);
    wb(1'b1, 8'h5c, 32'h3);
    r = irq_o;
    wb(1'b1, 8'h5c, 32'h0);
    chk({31'h0, r ^ irq_o}, 32'h1);
    wb(1'b1, 8'h58, 32'h1);
    rdchk(8'h58, 32'h0);
    eeprom_permit_i <= 1'b0;
    ev(2'h1);
    rdchk(8'h58, 32'h2);
    wb(1'b1, 8'h5c, 32'h2);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, 8'h58, 32'h2);
    chk({31'h0, irq_o}, 32'h0);
    rdchk(8'h7c, 32'h0);
    close_out;
  end
endmodule
